/* lcdws_defs.svh */
// offsets, field positions, reset values and timing counts of the macrocell
`ifndef LCDWS_DEFS_SVH
`define LCDWS_DEFS_SVH

`define CTRL_OFS 4'h0
`define LUT_OFS 4'h4
`define DATA_OFS 4'h8
`define STAT_OFS 4'hC

`define FUNC_LSB 0
`define WSEN_BIT 2
`define CKSEL_BIT 3
`define MODE_LSB 4
`define EDGE_LSB 8
`define INV_BIT 10
`define QSET_BIT 11
`define WSST_BIT 12
`define SHORT_BIT 13
`define MASK_LSB 16
`define CTRL_MASK 32'h000F_3F7F

`define CTRL_RST 32'h0000_0000
`define LUT_RST 16'h0000
`define DATA_RST 16'h0001

`define STAT_OUT_BIT 16
`define STAT_WAKE_BIT 17
`define STAT_ON_BIT 18

`define CLK_NS 25
`define STARTUP_NS 450000
`define SHORT_WAKE_NS 1000
`define STARTUP_CYC ((`STARTUP_NS + `CLK_NS - 1) / `CLK_NS)
`define SHORT_WAKE_CYC (`SHORT_WAKE_NS / `CLK_NS)

`endif

/* lcdws_pkg.sv */
// types shared by the lookup / counter / wake-sleep macrocell
`default_nettype none
package lcdws_pkg;
	typedef enum logic [1:0] {
		FUNC_LUT = 2'h0,
		FUNC_CNT = 2'h1,
		FUNC_RSV = 2'h2,
		FUNC_WS = 2'h3
	} func_t;
	typedef enum logic [2:0] {
		M_DELAY = 3'h0,
		M_ONESHOT = 3'h1,
		M_FREQ = 3'h2,
		M_EDGE = 3'h3,
		M_DEDGE = 3'h4,
		M_COUNT = 3'h5,
		M_RSV6 = 3'h6,
		M_RSV7 = 3'h7
	} mode_t;
	typedef enum logic [1:0] {
		EDGE_RISE = 2'h0,
		EDGE_FALL = 2'h1,
		EDGE_BOTH = 2'h2,
		EDGE_HIGH = 2'h3
	} edge_t;
	typedef enum logic [2:0] {
		PH_IDLE = 3'b001,
		PH_START = 3'b010,
		PH_ON = 3'b100
	} phase_t;
	typedef struct packed {
		logic ack;
		logic [31:0] rdat;
		logic [31:0] ctrl;
		logic [15:0] lut;
		logic [15:0] data;
		logic [8:0] s1;
		logic [8:0] s2;
		logic din_q;
		logic eck_q;
		logic [15:0] cnt;
		logic [15:0] cnt_d1;
		logic [15:0] cnt_d2;
		logic run;
		logic out;
		logic setrun;
		logic wake;
		phase_t ph;
		logic [15:0] phcnt;
		logic [3:0] hold;
		logic [3:0] pwr;
	} state_t;
endpackage
`default_nettype wire

/* lut_counter_delay_wake_sleep.sv */
// lookup table, 16-bit counter/delay and wake/sleep controller macrocell
// What this block does
// - lookup mode outputs truth-table bit indexed by inputs, input three MSB
// - one-shot starts a pulse on configured edge; width from data and clock
// - a control bit selects plain or inverted one-shot pulse
// - edges arriving during a one-shot pulse are ignored, no retrigger
// - frequency detect: close single edges raise output, timeout lowers it
// - both-edge frequency detect: short pulse raises output, timeout lowers
// - edge detect emits a short pulse per configured edge
// - delayed edge detect pulses after delay unless input changes meanwhile
// - delay mode shifts edges, restarts on new edge, filters short pulses
// - delay, one-shot, frequency counter value lags counter mode by two ticks
// - wake/sleep active when function field is 11 and enable bit set
// - wake/sleep powers selected comparators from the counter
// - sleep 1 to 65535 cycles; selected comparator outputs latched while asleep
// - oscillator off stops switching; comparators follow output state bit
// - sleep time is counter data cycles, wake time is one clock
// - reset hold clears counter, output high; release goes low until end
// - set hold stops counter, output low; release runs with output high
// - set/reset hold works only with high-level edge select
// - normal wake: on after start-up, stay on while wake is high
// - short wake: on after start-up, off after 1 us regardless
// - pause freezes count; direction up counts to 65535, down to 0
// - delay input, ext clock, direction, pause come from four inputs
`default_nettype none
`include "lcdws_defs.svh"

module lut_counter_delay_wake_sleep #(
	parameter int unsigned STARTUP_CYC = `STARTUP_CYC,
	parameter int unsigned SHORT_CYC = `SHORT_WAKE_CYC
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [3:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	input wire logic [3:0] matrix_in_i,
	input wire logic osc_pd_i,
	input wire logic [3:0] cmp_pu_i,
	input wire logic [3:0] cmp_raw_i,
	output logic out_o,
	output logic [3:0] cmp_pwr_o,
	output logic [3:0] cmp_o
);
	import lcdws_pkg::*;

	state_t r;
	state_t n;
	logic din, eck, up, keep, osc_off;
	logic rise, fall, sel_edge, tick, lvl_mode, hold_lvl, ws, term;
	logic req, shortw;
	logic [31:0] wv;
	func_t func;
	mode_t mode;
	edge_t esel;
	logic [15:0] cnt_vis;

	localparam logic [15:0] START_LAST = 16'(STARTUP_CYC - 1);
	localparam logic [15:0] SHORT_LAST = 16'(SHORT_CYC - 1);

	always_comb begin
		n = r;
		func = func_t'(r.ctrl[`FUNC_LSB +: 2]);
		mode = mode_t'(r.ctrl[`MODE_LSB +: 3]);
		esel = edge_t'(r.ctrl[`EDGE_LSB +: 2]);
		shortw = r.ctrl[`SHORT_BIT];
		// two flops per matrix, comparator output and oscillator input; only s2 is read
		n.s1 = {osc_pd_i, cmp_raw_i, matrix_in_i};
		n.s2 = r.s1;
		din = r.s2[0];
		eck = r.s2[1];
		up = r.s2[2];
		keep = r.s2[3];
		osc_off = r.s2[8];
		n.din_q = din;
		n.eck_q = eck;
		rise = din & ~r.din_q;
		fall = ~din & r.din_q;
		case (esel)
			EDGE_RISE: sel_edge = rise;
			EDGE_FALL: sel_edge = fall;
			EDGE_BOTH: sel_edge = rise | fall;
			default: sel_edge = rise;
		endcase
		// ext clock counted on its rising edge, internal every cycle
		tick = r.ctrl[`CKSEL_BIT] ? (eck & ~r.eck_q) : 1'b1;
		lvl_mode = (esel == EDGE_HIGH);
		hold_lvl = lvl_mode & din;
		ws = (func == FUNC_WS) & r.ctrl[`WSEN_BIT];
		term = up ? (r.cnt == 16'hFFFF) : (r.cnt == 16'h0000);
		cnt_vis = r.cnt;
		wv = 32'h0000_0000;

		// bus slave: ack one cycle after request, write on acked edge
		req = cyc_i & stb_i;
		n.ack = req & ~r.ack;
		if (req & ~r.ack) begin
			case (adr_i)
				`CTRL_OFS: n.rdat = r.ctrl;
				`LUT_OFS: n.rdat = {16'h0000, r.lut};
				`DATA_OFS: n.rdat = {16'h0000, r.data};
				`STAT_OFS: begin
					if ((mode == M_DELAY) | (mode == M_ONESHOT)
						| (mode == M_FREQ)) begin
						cnt_vis = r.cnt_d2;
					end
					n.rdat = 32'h0000_0000;
					n.rdat[15:0] = cnt_vis;
					n.rdat[`STAT_OUT_BIT] = r.out;
					n.rdat[`STAT_WAKE_BIT] = r.wake;
					n.rdat[`STAT_ON_BIT] = (r.ph == PH_ON);
				end
				default: n.rdat = 32'h0000_0000;
			endcase
		end
		if (req & r.ack & we_i) begin
			case (adr_i)
				`CTRL_OFS: wv = r.ctrl;
				`LUT_OFS: wv = {16'h0000, r.lut};
				default: wv = {16'h0000, r.data};
			endcase
			for (int b = 0; b < 4; b++) begin
				if (sel_i[b]) begin
					wv[8*b +: 8] = dat_i[8*b +: 8];
				end
			end
			case (adr_i)
				`CTRL_OFS: n.ctrl = wv & `CTRL_MASK;
				`LUT_OFS: n.lut = wv[15:0];
				`DATA_OFS: n.data = wv[15:0];
				default: n.ctrl = r.ctrl;
			endcase
		end

		if (tick) begin
			n.cnt_d1 = r.cnt;
			n.cnt_d2 = r.cnt_d1;
		end

		if (ws) begin
			n.out = r.wake;
			// oscillator down: frozen, wake level from state bit
			if (osc_off) begin
				n.wake = r.ctrl[`WSST_BIT];
				n.setrun = 1'b0;
			end else if (hold_lvl & ~r.ctrl[`QSET_BIT]) begin
				n.cnt = 16'h0000;
				n.wake = 1'b1;
				n.setrun = 1'b0;
			end else if (lvl_mode & fall & ~r.ctrl[`QSET_BIT]) begin
				// released: off until a full sleep count ends
				n.cnt = r.data;
				n.wake = 1'b0;
			end else if (hold_lvl) begin
				n.wake = 1'b0;
				n.setrun = 1'b1;
			end else if (tick) begin
				n.wake = r.setrun;
				if (~keep) begin
					if (term) begin
						// one tick of wake per sleep period
						n.cnt = r.data;
						n.wake = 1'b1;
						n.setrun = 1'b0;
					end else if (up) begin
						n.cnt = r.cnt + 16'h0001;
					end else begin
						n.cnt = r.cnt - 16'h0001;
					end
				end
			end
			case (r.ph)
				PH_IDLE: begin
					if (r.wake) begin
						n.ph = PH_START;
						n.phcnt = 16'h0000;
					end
				end
				PH_START: begin
					// short wake runs on even if the wake tick is gone
					if (~r.wake & ~shortw) begin
						n.ph = PH_IDLE;
					end else if (r.phcnt >= START_LAST) begin
						n.ph = PH_ON;
						n.phcnt = 16'h0000;
					end else begin
						n.phcnt = r.phcnt + 16'h0001;
					end
				end
				PH_ON: begin
					n.hold = r.s2[7:4];
					n.phcnt = r.phcnt + 16'h0001;
					if (shortw ? (r.phcnt >= SHORT_LAST) : ~r.wake) begin
						n.ph = PH_IDLE;
					end
				end
				default: n.ph = PH_IDLE;
			endcase
			for (int i = 0; i < 4; i++) begin
				n.pwr[i] = cmp_pu_i[i]
					& (~r.ctrl[`MASK_LSB + i] | (r.ph != PH_IDLE));
				n.hold[i] = (r.ctrl[`MASK_LSB + i] & (r.ph != PH_ON))
					? r.hold[i] : r.s2[4 + i];
			end
		end else begin
			n.ph = PH_IDLE;
			n.wake = 1'b0;
			n.setrun = 1'b0;
			n.pwr = cmp_pu_i;
			n.hold = r.s2[7:4];
			if (func == FUNC_LUT) begin
				n.out = r.lut[r.s2[3:0]];
				n.run = 1'b0;
			end else begin
				case (mode)
					M_ONESHOT: begin
						if (~r.run & sel_edge) begin
							n.run = 1'b1;
							n.cnt = r.data;
						end else if (r.run & tick) begin
							// incoming edges not looked at while running
							if (r.cnt == 16'h0000) begin
								n.run = 1'b0;
							end else begin
								n.cnt = r.cnt - 16'h0001;
							end
						end
						n.out = n.run ^ r.ctrl[`INV_BIT];
					end
					M_FREQ: begin
						if (sel_edge) begin
							// edge inside running window: fast enough
							if (r.run) begin
								n.out = 1'b1;
							end
							n.run = 1'b1;
							n.cnt = r.data;
						end else if (r.run & tick) begin
							if (r.cnt == 16'h0000) begin
								n.run = 1'b0;
								n.out = 1'b0;
							end else begin
								n.cnt = r.cnt - 16'h0001;
							end
						end
					end
					M_EDGE: n.out = sel_edge;
					M_DEDGE: begin
						n.out = 1'b0;
						if (sel_edge) begin
							n.run = 1'b1;
							n.cnt = r.data;
						end else if (rise | fall) begin
							n.run = 1'b0;
						end else if (r.run & tick) begin
							if (r.cnt == 16'h0000) begin
								n.run = 1'b0;
								n.out = 1'b1;
							end else begin
								n.cnt = r.cnt - 16'h0001;
							end
						end
					end
					M_COUNT: begin
						n.out = 1'b0;
						n.run = 1'b0;
						if (hold_lvl | sel_edge) begin
							n.cnt = r.data;
						end else if (tick & ~keep) begin
							if (term) begin
								n.cnt = r.data;
								n.out = 1'b1;
							end else if (up) begin
								n.cnt = r.cnt + 16'h0001;
							end else begin
								n.cnt = r.cnt - 16'h0001;
							end
						end
					end
					default: begin
						// delay: unselected edge passes at once, cancels
						if (sel_edge) begin
							n.run = 1'b1;
							n.cnt = r.data;
						end else if (rise | fall) begin
							n.run = 1'b0;
							n.out = din;
						end else if (r.run & tick) begin
							if (r.cnt == 16'h0000) begin
								n.run = 1'b0;
								n.out = din;
							end else begin
								n.cnt = r.cnt - 16'h0001;
							end
						end
					end
				endcase
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			r <= '{ack: 1'b0, rdat: 32'h0000_0000, ctrl: `CTRL_RST,
				lut: `LUT_RST, data: `DATA_RST, s1: 9'h000, s2: 9'h000,
				din_q: 1'b0, eck_q: 1'b0, cnt: 16'h0000,
				cnt_d1: 16'h0000, cnt_d2: 16'h0000, run: 1'b0,
				out: 1'b0, setrun: 1'b0, wake: 1'b0, ph: PH_IDLE,
				phcnt: 16'h0000, hold: 4'h0, pwr: 4'h0};
		end else begin
			r <= n;
		end
	end

	assign ack_o = r.ack;
	assign dat_o = r.rdat;
	assign out_o = r.out;
	assign cmp_pwr_o = r.pwr;
	assign cmp_o = r.hold;
endmodule
`default_nettype wire

/* lcdws_chk_props.sv */
// bus and power checks at the ports of the macrocell
`default_nettype none
`include "lcdws_defs.svh"
module lcdws_chk (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [3:0] adr_i,
	input wire logic [31:0] dat_o,
	input wire logic ack_o,
	input wire logic [3:0] cmp_pu_i,
	input wire logic out_o,
	input wire logic [3:0] cmp_pwr_o,
	input wire logic [3:0] cmp_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence s_req;
		cyc_i && stb_i && !ack_o;
	endsequence
	sequence s_rd;
		ack_o && !we_i;
	endsequence
	a_ack_next: assert property (s_req |=> ack_o)
		else $error("request not answered next cycle");
	a_ack_single: assert property (ack_o |=> !ack_o)
		else $error("ack longer than one cycle");
	a_ack_cause: assert property ($rose(ack_o) |-> $past(cyc_i && stb_i))
		else $error("ack without request");
	a_reset_quiet: assert property ($fell(rst_i) |->
		!ack_o && !out_o && cmp_pwr_o == 4'h0 && cmp_o == 4'h0)
		else $error("outputs not cleared by reset");
	a_pwr_req: assert property (
		(cmp_pwr_o & ~$past(cmp_pu_i)) == 4'h0)
		else $error("comparator powered without request");
	a_half_upper: assert property (s_rd ##0
		(adr_i == `LUT_OFS || adr_i == `DATA_OFS) |-> dat_o[31:16] == 16'h0000)
		else $error("upper half of short register not zero");
	a_unmapped_zero: assert property (s_rd ##0 adr_i[1:0] != 2'h0
		|-> dat_o == 32'h0000_0000)
		else $error("unmapped read not zero");
	a_ctrl_reserved: assert property (s_rd ##0 adr_i == `CTRL_OFS
		|-> (dat_o & ~`CTRL_MASK) == 32'h0000_0000)
		else $error("reserved control bits read back set");
endmodule
bind lut_counter_delay_wake_sleep lcdws_chk chk_u (.clk_i, .rst_i, .cyc_i,
	.stb_i, .we_i, .adr_i, .dat_o, .ack_o, .cmp_pu_i, .out_o, .cmp_pwr_o,
	.cmp_o);
`default_nettype wire

/* matrix_side_model.sv */
// far-side model: matrix drivers and comparators around the macrocell
`default_nettype none
module matrix_side_model (
	input wire logic clk_i,
	input wire logic [3:0] lvl_i,
	input wire logic pd_i,
	output logic [3:0] matrix_o,
	output logic osc_pd_o,
	output logic [3:0] pu_o,
	output logic [3:0] raw_o
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		matrix_o = 4'h0;
		osc_pd_o = 1'b0;
		pu_o = 4'hF;
		raw_o = 4'h5;
	end
	// one clock of routing lag, like logic in the matrix
	always @(posedge clk_i) begin
		matrix_o <= lvl_i;
		osc_pd_o <= pd_i;
		pu_o <= 4'hF;
		raw_o <= ~raw_o;
	end
endmodule
`default_nettype wire

/* lut_counter_delay_wake_sleep_tb.sv */
// self-checking bench for the lookup / counter / wake-sleep macrocell
`default_nettype none
`include "lcdws_defs.svh"
module lut_counter_delay_wake_sleep_tb import lcdws_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst, cyc, stb, we, pd, out, ack, osd;
	logic [3:0] adr, sel, lvl, mtx, pu, raw, pwr, cmpo;
	logic [31:0] wdat, rdat;
	int n_errors = 0;
	int cmp_count = 0;
	lut_counter_delay_wake_sleep #(.STARTUP_CYC(8), .SHORT_CYC(4)) dut_u (
		.clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we),
		.adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
		.matrix_in_i(mtx), .osc_pd_i(osd), .cmp_pu_i(pu), .cmp_raw_i(raw),
		.out_o(out), .cmp_pwr_o(pwr), .cmp_o(cmpo));
	matrix_side_model side_u (.clk_i(clk), .lvl_i(lvl), .pd_i(pd),
		.matrix_o(mtx), .osc_pd_o(osd), .pu_o(pu), .raw_o(raw));
	task automatic wrap_up();
		$display("compares %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask
	// waits on ack with no cycle count assumed; the watchdog ends a hang
	task automatic wb(input logic w, input logic [3:0] a,
		input logic [31:0] d, input logic [3:0] s, output logic [31:0] q);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= s;
		wdat <= d;
		// ack and read data taken at the same rising edge
		do @(posedge clk); while (ack !== 1'b1);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		logic [31:0] q;
		wb(1'b1, a, d, 4'hF, q);
	endtask
	task automatic rdc(input logic [3:0] a, input logic [31:0] e);
		logic [31:0] q;
		wb(1'b0, a, 32'h0000_0000, 4'hF, q);
		check(q, e);
	endtask
	task automatic pulse(input int n);
		@(posedge clk);
		lvl <= 4'h1;
		repeat (n) @(posedge clk);
		lvl <= 4'h0;
	endtask
	task automatic watch(input int n, output int hi, output int ri);
		logic p;
		hi = 0;
		ri = 0;
		p = out;
		repeat (n) begin
			@(negedge clk);
			hi += (out === 1'b1);
			ri += (out === 1'b1 && p !== 1'b1);
			p = out;
		end
	endtask
	function automatic logic [31:0] cfg(func_t f, mode_t m, edge_t e);
		return 32'(f) | (32'(m) << `MODE_LSB) | (32'(e) << `EDGE_LSB);
	endfunction
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	initial begin
		repeat (5000) @(posedge clk);
		n_errors++;
		wrap_up();
	end
	initial begin
		int hi, ri;
		logic [31:0] q, q2;
		time t0;
		rst = 1'b1;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 4'h0;
		wdat = 32'h0000_0000;
		sel = 4'hF;
		lvl = 4'h0;
		pd = 1'b0;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		rdc(`CTRL_OFS, `CTRL_RST);
		rdc(`LUT_OFS, 32'(`LUT_RST));
		rdc(`DATA_OFS, 32'(`DATA_RST));
		wr(4'h2, 32'hFFFF_FFFF);
		rdc(4'h2, 32'h0000_0000);
		wr(`CTRL_OFS, 32'hFFFF_FFFF);
		rdc(`CTRL_OFS, `CTRL_MASK);
		wr(`CTRL_OFS, 32'h0000_0000);
		wr(`LUT_OFS, 32'h0000_1E2D);
		for (int i = 0; i < 16; i++) begin
			lvl <= 4'(i);
			repeat (6) @(posedge clk);
			check(out, 1'(32'h0000_1E2D >> i));
		end
		lvl <= 4'h0;
		// low lane only: the upper byte must survive
		wb(1'b1, `LUT_OFS, 32'hFFFF_FFFF, 4'h1, q);
		rdc(`LUT_OFS, 32'h0000_1EFF);
		wr(`DATA_OFS, 32'h0000_0006);
		for (int v = 0; v < 2; v++) begin
			wr(`CTRL_OFS, cfg(FUNC_CNT, M_ONESHOT, EDGE_RISE) | (v << `INV_BIT));
			// let the output settle in the new mode first
			repeat (2) @(posedge clk);
			fork
				begin
					pulse(3);
					pulse(2);
				end
				watch(40, hi, ri);
			join
			check(v ? 40 - hi : hi, 7);
			check(ri, 1);
		end
		for (int e = 0; e < 3; e++) begin
			wr(`CTRL_OFS, cfg(FUNC_CNT, M_EDGE, edge_t'(e)));
			repeat (2) @(posedge clk);
			fork
				pulse(4);
				watch(20, hi, ri);
			join
			check(ri, e == 2 ? 2 : 1);
		end
		// 3-tick pulse then 12-tick pulse, window of 7 ticks
		for (int k = 0; k < 3; k++) begin
			wr(`CTRL_OFS, cfg(FUNC_CNT, k == 0 ? M_DELAY
				: k == 1 ? M_FREQ : M_DEDGE, EDGE_RISE));
			repeat (2) @(posedge clk);
			fork
				begin
					pulse(3);
					pulse(12);
				end
				watch(40, hi, ri);
			join
			// delay: 12 less 7; freq: one window; delayed edge: one tick
			check(hi, k == 0 ? 5 : k == 1 ? 7 : 1);
			check(ri, 1);
		end
		wr(`CTRL_OFS, cfg(FUNC_CNT, M_COUNT, EDGE_RISE));
		wr(`DATA_OFS, 32'h0000_0064);
		// rising reset input reloads data, pause holds it there
		lvl <= 4'h9;
		repeat (6) @(posedge clk);
		wb(1'b0, `STAT_OFS, 32'h0000_0000, 4'hF, q);
		wb(1'b0, `STAT_OFS, 32'h0000_0000, 4'hF, q2);
		check(q[15:0], 16'h0064);
		check(q2[15:0], q[15:0]);
		lvl <= 4'h0;
		repeat (6) @(posedge clk);
		wb(1'b0, `STAT_OFS, 32'h0000_0000, 4'hF, q);
		wb(1'b0, `STAT_OFS, 32'h0000_0000, 4'hF, q2);
		// the two reads sample three ticks apart while counting down
		check(16'(q[15:0] - q2[15:0]), 3);
		wr(`DATA_OFS, 32'h0000_001E);
		wr(`CTRL_OFS, 32'h0001_0007);
		@(posedge pwr[0]);
		t0 = $time;
		@(posedge pwr[0]);
		check(32'(($time - t0) / `CLK_NS), 31);
		wr(`CTRL_OFS, 32'h0001_0007 | (1 << `SHORT_BIT));
		@(posedge pwr[0]);
		hi = 0;
		repeat (31) begin
			@(negedge clk);
			hi += (pwr[0] === 1'b1);
		end
		// start-up 8 plus short on time 4 of the bench's parameters
		check(hi, 12);
		// level reset input held: cleared and awake; released: asleep
		wr(`CTRL_OFS, 32'h0001_0307);
		lvl <= 4'h1;
		repeat (16) @(posedge clk);
		check(out, 1);
		wb(1'b0, `STAT_OFS, 32'h0000_0000, 4'hF, q);
		check(q[15:0], 16'h0000);
		lvl <= 4'h0;
		repeat (6) @(posedge clk);
		check(out, 0);
		wr(`CTRL_OFS, 32'h0001_0B07);
		lvl <= 4'h1;
		repeat (6) @(posedge clk);
		check(out, 0);
		lvl <= 4'h0;
		repeat (6) @(posedge clk);
		check(out, 1);
		for (int s = 0; s < 2; s++) begin
			wr(`CTRL_OFS, 32'h0001_0007 | (s << `WSST_BIT));
			pd <= 1'b1;
			repeat (10) @(posedge clk);
			hi = 0;
			repeat (40) begin
				@(negedge clk);
				hi += (pwr[0] === 1'b1);
			end
			check(hi, s ? 40 : 0);
		end
		wrap_up();
	end
endmodule
`default_nettype wire
